/* rtl/pfc_host.sv */
// host controller that drives the parallel flash through its pins
// How it works
// RULE1 - sectors are fixed size; sector erase addresses any byte inside one
// RULE2 - boot region is sixteen sectors, top or bottom; host needs no special handling
// RULE3 - reads drive chip enable and output gate low together
// RULE4 - write strobe is high before and during every read
// RULE5 - device floats data once output gate or chip enable rises
// RULE6 - chip enable high means standby; host idles there
// RULE7 - program sends AA, 55, A0 unlock then target address and byte
// RULE8 - address is valid before the later falling strobe edge; the host changes it on the same clock edge as both strobes fall
// RULE9 - data is valid through the earlier rising strobe edge
// RULE10 - sector erase sends the six-cycle sequence ending 30H in the sector
// RULE11 - caller must erase before programming; bits only go toward zero
// RULE12 - host never issues a program while an erase is running
// RULE13 - erase end is found by polling and toggle bit together
// RULE14 - erased bytes read all ones; erase ends when poll bit reads one
// RULE15 - chip erase uses six cycles ending 10H at 5555H
// RULE16 - program end is when poll bit equals the loaded bit
// RULE17 - operation end is when toggle bit stops alternating
// RULE18 - id mode reads manufacturer at select low, device code at select high
// RULE19 - F0H write exits to read mode; unlock ending 90H enters id mode
`include "pfc_cfg.svh"
`default_nettype none
module pfc_host
   import pfc_pkg::*;
(
   // clock, reset and enable
   input wire logic REF_CLK_I,
   input wire logic RESET_I,
   input wire logic CLK_EN_I,
   // command port
   input wire logic CMD_VALID_I,
   output logic CMD_READY_O,
   input wire logic [2:0] CMD_OP_I,
   input wire logic [16:0] CMD_ADDR_I,
   input wire logic [7:0] CMD_DATA_I,
   output logic DONE_O,
   output logic [7:0] RDATA_O,
   output logic BUSY_O,
   // flash pins
   output logic FLASH_CE_N_O,
   output logic FLASH_OE_N_O,
   output logic FLASH_WE_N_O,
   output logic [16:0] FLASH_ADDR_O,
   output logic [7:0] FLASH_DQ_O,
   output logic FLASH_DQ_OE_O,
   input wire logic [7:0] FLASH_DQ_I
);
   typedef enum logic [2:0] {H_IDLE, H_SEND, H_POLL, H_READ, H_DONE} pfc_host_st_e;
   pfc_host_st_e st;
   pfc_op_e op;
   logic [2:0] step;
   logic [16:0] tgt_addr;
   logic [7:0] tgt_data;
   logic [7:0] prev_rd;
   logic have_prev;
   logic [7:0] rdata;
   logic [7:0] dq_s1, dq_s2, dq_s3;
   logic [7:0] dq_stable;
   pfc_cyc_if cyc ();

   // three-stage pin synchroniser; value accepted once stages two and three agree
   always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         dq_s1 <= 8'h00;
         dq_s2 <= 8'h00;
         dq_s3 <= 8'h00;
         dq_stable <= 8'h00;
      end else if (CLK_EN_I) begin
         dq_s1 <= FLASH_DQ_I;
         dq_s2 <= dq_s1;
         dq_s3 <= dq_s2;
         if (dq_s2 == dq_s3) dq_stable <= dq_s3;
      end
   end

   // number of write cycles per operation
   logic [2:0] n_writes;
   always_comb begin
      case (op)
         PFC_OP_PROGRAM: n_writes = 3'd4; // [RULE7]
         PFC_OP_SECTOR_ERASE: n_writes = 3'd6; // [RULE10]
         PFC_OP_CHIP_ERASE: n_writes = 3'd6; // [RULE15]
         PFC_OP_READ_RESET: n_writes = 3'd1; // [RULE19]
         PFC_OP_ID_ENTER: n_writes = 3'd3; // [RULE19]
         PFC_OP_ID_EXIT: n_writes = 3'd3; // [RULE19]
         default: n_writes = 3'd0;
      endcase
   end

   // address and data of each command step
   logic [16:0] step_addr;
   logic [7:0] step_data;
   wire last_step = (step == n_writes - 3'd1);
   always_comb begin
      step_addr = `PFC_UNLOCK_ADDR1;
      step_data = `PFC_UNLOCK_DATA1;
      case (step)
         3'd0: begin
            if (op == PFC_OP_READ_RESET) begin
               step_addr = tgt_addr;
               step_data = `PFC_CMD_READ_RESET;
            end
         end
         3'd1, 3'd4: begin
            step_addr = `PFC_UNLOCK_ADDR2;
            step_data = `PFC_UNLOCK_DATA2;
         end
         3'd2: begin
            case (op)
               PFC_OP_PROGRAM: step_data = `PFC_CMD_PROGRAM;
               PFC_OP_ID_ENTER: step_data = `PFC_CMD_AUTOSELECT;
               PFC_OP_ID_EXIT: step_data = `PFC_CMD_READ_RESET;
               default: step_data = `PFC_CMD_ERASE_SETUP;
            endcase
         end
         3'd3: begin
            if (op == PFC_OP_PROGRAM) begin
               step_addr = tgt_addr;
               step_data = tgt_data; // only clears bits; caller erases first [RULE11]
            end
         end
         3'd5: begin
            if (op == PFC_OP_SECTOR_ERASE) begin
               step_addr = tgt_addr; // any byte of the chosen sector [RULE1] [RULE10]
               step_data = `PFC_CMD_SECTOR_ERASE;
            end else begin
               step_data = `PFC_CMD_CHIP_ERASE; // [RULE15]
            end
         end
         default: begin
            step_addr = `PFC_UNLOCK_ADDR1;
            step_data = `PFC_UNLOCK_DATA1;
         end
      endcase
   end

   // completion test on a status read
   wire is_erase = (op == PFC_OP_SECTOR_ERASE) || (op == PFC_OP_CHIP_ERASE);
   wire [7:0] expect_byte = is_erase ? `PFC_ERASED_BYTE : tgt_data; // [RULE14]
   wire poll_ok = (cyc.rdata[`PFC_POLL_BIT] == expect_byte[`PFC_POLL_BIT]); // [RULE16]
   wire toggle_stopped = have_prev &&
      (cyc.rdata[`PFC_TOGGLE_BIT] == prev_rd[`PFC_TOGGLE_BIT]); // [RULE17]
   wire op_finished = poll_ok && toggle_stopped; // both methods must agree [RULE13]
   wire is_write_op = (op != PFC_OP_READ);

   // cycle requests to the engine
   assign cyc.req = (st == H_SEND) || (st == H_POLL) || (st == H_READ);
   assign cyc.is_write = (st == H_SEND);
   assign cyc.addr = (st == H_SEND) ? step_addr : tgt_addr;
   assign cyc.wdata = step_data;

   // command acceptance; one command at a time keeps programs out of a running erase
   assign CMD_READY_O = (st == H_IDLE); // [RULE12]
   assign BUSY_O = (st != H_IDLE);
   assign RDATA_O = rdata;

   // host command sequencer
   always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         st <= H_IDLE;
         op <= PFC_OP_READ;
         step <= 3'd0;
         tgt_addr <= 17'h00000;
         tgt_data <= 8'h00;
         prev_rd <= 8'h00;
         have_prev <= 1'b0;
         rdata <= 8'h00;
         DONE_O <= 1'b0;
      end else if (CLK_EN_I) begin
         DONE_O <= 1'b0;
         case (st)
            H_IDLE: begin
               if (CMD_VALID_I) begin
                  op <= pfc_op_e'(CMD_OP_I);
                  tgt_addr <= CMD_ADDR_I;
                  tgt_data <= CMD_DATA_I;
                  step <= 3'd0;
                  have_prev <= 1'b0;
                  st <= (CMD_OP_I == 3'(PFC_OP_READ)) ? H_READ : H_SEND;
               end
            end
            H_SEND: begin
               if (cyc.done) begin
                  step <= step + 3'd1;
                  if (last_step) begin
                     st <= (is_erase || op == PFC_OP_PROGRAM) ? H_POLL : H_DONE;
                  end
               end
            end
            H_POLL: begin
               if (cyc.done) begin
                  prev_rd <= cyc.rdata;
                  have_prev <= 1'b1;
                  if (op_finished) st <= H_DONE;
               end
            end
            H_READ: begin
               if (cyc.done) begin
                  rdata <= cyc.rdata; // id codes read here at select bit low/high [RULE18]
                  st <= H_DONE;
               end
            end
            H_DONE: begin
               DONE_O <= 1'b1;
               st <= H_IDLE;
            end
            default: st <= H_IDLE;
         endcase
         if (st == H_POLL && is_write_op && cyc.done) rdata <= cyc.rdata;
      end
   end

   // pin-level cycle engine
   pfc_bus_cycle u_cycle (
      .clk(REF_CLK_I),
      .rst(RESET_I),
      .ce(CLK_EN_I),
      .cyc(cyc),
      .chip_enable_n(FLASH_CE_N_O),
      .output_gate_n(FLASH_OE_N_O),
      .write_strobe_n(FLASH_WE_N_O),
      .addr(FLASH_ADDR_O),
      .dq_out(FLASH_DQ_O),
      .dq_oe(FLASH_DQ_OE_O),
      .dq_sync(dq_stable)
   );
endmodule : pfc_host
`default_nettype wire

/* rtl/pfc_cfg.svh */
// timing, address and command constants for the parallel flash host controller
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH
`define PFC_UNLOCK_ADDR1 17'h05555
`define PFC_UNLOCK_ADDR2 17'h02aaa
`define PFC_UNLOCK_DATA1 8'haa
`define PFC_UNLOCK_DATA2 8'h55
`define PFC_CMD_PROGRAM 8'ha0
`define PFC_CMD_ERASE_SETUP 8'h80
`define PFC_CMD_SECTOR_ERASE 8'h30
`define PFC_CMD_CHIP_ERASE 8'h10
`define PFC_CMD_READ_RESET 8'hf0
`define PFC_CMD_AUTOSELECT 8'h90
`define PFC_ERASED_BYTE 8'hff
`define PFC_SECTOR_BYTES 512
`define PFC_SECTOR_COUNT 256
`define PFC_BOOT_SECTORS 16
`define PFC_BOOT_TOP_BASE 17'h1e000
`define PFC_POLL_BIT 7
`define PFC_TOGGLE_BIT 6
`define PFC_CLK_PERIOD_PS 5000
`define PFC_STROBE_LOW_PS 50000
`define PFC_STROBE_HIGH_PS 40000
`define PFC_READ_ACCESS_PS 100000
`define PFC_FLOAT_PS 30000
`define PFC_STROBE_LOW_CYC ((`PFC_STROBE_LOW_PS + `PFC_CLK_PERIOD_PS - 1) / `PFC_CLK_PERIOD_PS)
`define PFC_STROBE_HIGH_CYC ((`PFC_STROBE_HIGH_PS + `PFC_CLK_PERIOD_PS - 1) / `PFC_CLK_PERIOD_PS)
`define PFC_READ_ACCESS_CYC ((`PFC_READ_ACCESS_PS + `PFC_CLK_PERIOD_PS - 1) / `PFC_CLK_PERIOD_PS)
`define PFC_FLOAT_CYC ((`PFC_FLOAT_PS + `PFC_CLK_PERIOD_PS - 1) / `PFC_CLK_PERIOD_PS)
`endif

/* rtl/pfc_pkg.sv */
// types for the parallel flash host controller
`default_nettype none
package pfc_pkg;
   typedef enum logic [2:0] {
      PFC_OP_READ,
      PFC_OP_PROGRAM,
      PFC_OP_SECTOR_ERASE,
      PFC_OP_CHIP_ERASE,
      PFC_OP_READ_RESET,
      PFC_OP_ID_ENTER,
      PFC_OP_ID_EXIT
   } pfc_op_e;
   typedef logic [16:0] pfc_addr_t;
   typedef logic [7:0] pfc_byte_t;
endpackage : pfc_pkg
`default_nettype wire

/* rtl/pfc_cyc_if.sv */
// carrier between the sequencer and the bus cycle engine
`default_nettype none
interface pfc_cyc_if;
   logic req;
   logic is_write;
   logic [16:0] addr;
   logic [7:0] wdata;
   logic done;
   logic [7:0] rdata;
   modport seq (output req, output is_write, output addr, output wdata,
      input done, input rdata);
   modport eng (input req, input is_write, input addr, input wdata,
      output done, output rdata);
endinterface : pfc_cyc_if
`default_nettype wire

/* rtl/pfc_bus_cycle.sv */
// one read or write bus cycle on the flash pins
`include "pfc_cfg.svh"
`default_nettype none
module pfc_bus_cycle (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // sequencer side
   pfc_cyc_if.eng cyc,
   // flash pins
   output logic chip_enable_n,
   output logic output_gate_n,
   output logic write_strobe_n,
   output logic [16:0] addr,
   output logic [7:0] dq_out,
   output logic dq_oe,
   input wire logic [7:0] dq_sync
);
   typedef enum logic [2:0] {S_IDLE, S_WLOW, S_WHIGH, S_RACC, S_RFLOAT} pfc_cyc_st_e;
   localparam logic [7:0] LOW_CYC = 8'(`PFC_STROBE_LOW_CYC);
   localparam logic [7:0] HIGH_CYC = 8'(`PFC_STROBE_HIGH_CYC);
   localparam logic [7:0] ACC_CYC = 8'(`PFC_READ_ACCESS_CYC + 3);
   localparam logic [7:0] FLT_CYC = 8'(`PFC_FLOAT_CYC);
   pfc_cyc_st_e st;
   logic [7:0] cnt;
   logic [7:0] rdata;
   wire cnt_zero = (cnt == 8'h00);
   assign cyc.rdata = rdata;
   assign cyc.done = ce && cnt_zero && (st == S_WHIGH || st == S_RFLOAT);
   // strobe sequencing; write strobe and chip enable fall on the same edge and rise on the same edge here
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st <= S_IDLE;
         cnt <= 8'h00;
         chip_enable_n <= 1'b1;
         output_gate_n <= 1'b1;
         write_strobe_n <= 1'b1;
         addr <= 17'h00000;
         dq_out <= 8'h00;
         dq_oe <= 1'b0;
         rdata <= 8'h00;
      end else if (ce) begin
         if (!cnt_zero) cnt <= cnt - 8'h01;
         case (st)
            S_IDLE: begin
               if (cyc.req) begin
                  addr <= cyc.addr;
                  chip_enable_n <= 1'b0;
                  if (cyc.is_write) begin
                     output_gate_n <= 1'b1; // gate high inhibits device output
                     write_strobe_n <= 1'b0; // address taken on the later falling edge [RULE8]
                     dq_out <= cyc.wdata;
                     dq_oe <= 1'b1;
                     cnt <= LOW_CYC;
                     st <= S_WLOW;
                  end else begin
                     write_strobe_n <= 1'b1; // strobe stays high through a read [RULE4]
                     output_gate_n <= 1'b0; // both low to read [RULE3]
                     dq_oe <= 1'b0;
                     cnt <= ACC_CYC;
                     st <= S_RACC;
                  end
               end
            end
            S_WLOW: begin
               if (cnt_zero) begin
                  write_strobe_n <= 1'b1; // data taken on the earlier rising edge [RULE9]
                  chip_enable_n <= 1'b1;
                  cnt <= HIGH_CYC;
                  st <= S_WHIGH;
               end
            end
            S_WHIGH: begin
               if (cnt_zero) begin
                  dq_oe <= 1'b0;
                  st <= S_IDLE;
               end
            end
            S_RACC: begin
               if (cnt_zero) begin
                  rdata <= dq_sync;
                  output_gate_n <= 1'b1; // device floats its pins on this edge [RULE5]
                  chip_enable_n <= 1'b1; // standby between cycles [RULE6]
                  cnt <= FLT_CYC;
                  st <= S_RFLOAT;
               end
            end
            S_RFLOAT: begin
               if (cnt_zero) st <= S_IDLE;
            end
            default: st <= S_IDLE;
         endcase
      end
   end
endmodule : pfc_bus_cycle
`default_nettype wire

/* dv/pfc_host_chk.sv */
// pin-level checks on the parallel flash host controller
`include "pfc_cfg.svh"
`default_nettype none
module pfc_host_chk (
   // clock and reset
   input wire logic REF_CLK_I,
   input wire logic RESET_I,
   // command status
   input wire logic CMD_READY_O,
   input wire logic DONE_O,
   // flash pins
   input wire logic FLASH_CE_N_O,
   input wire logic FLASH_OE_N_O,
   input wire logic FLASH_WE_N_O,
   input wire logic [16:0] FLASH_ADDR_O,
   input wire logic [7:0] FLASH_DQ_O,
   input wire logic FLASH_DQ_OE_O
);
   localparam int LO_MIN = `PFC_STROBE_LOW_CYC;
   localparam int ACC_MIN = `PFC_READ_ACCESS_CYC;
   logic [7:0] lo_cnt;
   logic [7:0] oe_cnt;
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (RESET_I);
   // count how long strobe and output gate have been low
   always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         lo_cnt <= 8'h00;
         oe_cnt <= 8'h00;
      end else begin
         lo_cnt <= FLASH_WE_N_O ? 8'h00 : lo_cnt + 8'h01;
         oe_cnt <= FLASH_OE_N_O ? 8'h00 : oe_cnt + 8'h01;
      end
   end
   // steps of a bus cycle
   sequence wr_rise;
      $rose(FLASH_WE_N_O);
   endsequence
   sequence rd_win;
      !FLASH_CE_N_O && !FLASH_OE_N_O;
   endsequence
   read_we_high_a: assert property (rd_win |-> FLASH_WE_N_O && !FLASH_DQ_OE_O)
      else $error("strobe or drive during read");
   read_access_a: assert property ($rose(FLASH_OE_N_O) |-> oe_cnt >= ACC_MIN)
      else $error("read gate too short");
   ce_with_we_a: assert property ($fell(FLASH_WE_N_O) |-> !FLASH_CE_N_O && FLASH_OE_N_O)
      else $error("write strobe without chip enable");
   strobe_hold_a: assert property (!FLASH_WE_N_O && !$past(FLASH_WE_N_O)
      |-> $stable(FLASH_ADDR_O) && $stable(FLASH_DQ_O) && FLASH_DQ_OE_O)
      else $error("address or data moved in strobe");
   data_at_rise_a: assert property (wr_rise |-> FLASH_DQ_OE_O && $stable(FLASH_DQ_O))
      else $error("data not held at strobe rise");
   strobe_width_a: assert property (wr_rise |-> lo_cnt >= LO_MIN)
      else $error("write strobe too short");
   idle_standby_a: assert property (CMD_READY_O |-> FLASH_CE_N_O && !FLASH_DQ_OE_O)
      else $error("idle without standby");
   done_ready_a: assert property (DONE_O |-> CMD_READY_O ##1 !DONE_O)
      else $error("done not in idle or longer than one cycle");
endmodule : pfc_host_chk
bind pfc_host pfc_host_chk u_pfc_host_chk (.REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I),
   .CMD_READY_O(CMD_READY_O), .DONE_O(DONE_O), .FLASH_CE_N_O(FLASH_CE_N_O),
   .FLASH_OE_N_O(FLASH_OE_N_O), .FLASH_WE_N_O(FLASH_WE_N_O), .FLASH_ADDR_O(FLASH_ADDR_O),
   .FLASH_DQ_O(FLASH_DQ_O), .FLASH_DQ_OE_O(FLASH_DQ_OE_O));
`default_nettype wire

/* dv/pfc_flash_model.sv */
// behavioural parallel flash device driven by the host controller
`default_nettype none
module pfc_flash_model #(
   parameter logic [7:0] MFR_CODE = 8'h3c, // arbitrary value
   parameter logic [7:0] DEV_CODE = 8'h5e, // arbitrary value
   parameter realtime T_PROG = 2000.0,
   parameter realtime T_ERASE = 5000.0
) (
   // device pins
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic [16:0] addr_i,
   input wire logic [7:0] dq_i,
   output logic [7:0] dq_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mem [logic [16:0]]; // flat array, boot region unlocked
   logic [16:0] wa;
   logic [7:0] wd;
   logic [7:0] rd_q = 8'h00;
   logic [7:0] ld = 8'hff;
   logic [1:0] st = 2'h0;
   logic wr = 1'b0;
   logic esu = 1'b0;
   logic idm = 1'b0;
   logic tog = 1'b0;
   realtime busy_end = 0.0;
   // data only while chip and gate are low, otherwise inverse of last value
   assign dq_o = (!ce_n_i && !oe_n_i && we_n_i) ? rd_q : ~rd_q;
   // read value picked as the read opens
   always @(negedge ce_n_i or negedge oe_n_i) begin
      #1; // let address and both enables settle; one value per read
      if (!ce_n_i && !oe_n_i && we_n_i) begin
         if ($realtime < busy_end) begin
            tog = ~tog;
            rd_q = {~ld[7], tog, ld[5:0]};
         end else if (idm) begin
            rd_q = addr_i[0] ? DEV_CODE : MFR_CODE;
         end else begin
            rd_q = mem.exists(addr_i) ? mem[addr_i] : 8'hff;
         end
      end
   end
   // address on the later falling strobe edge
   always @(negedge ce_n_i or negedge we_n_i) begin
      #1; // both strobes and the address move on the same host edge
      if (!ce_n_i && !we_n_i && oe_n_i) begin
         wa = addr_i;
         wr = 1'b1;
      end
   end
   // data on the earlier rising strobe edge, then command decode
   always @(posedge ce_n_i or posedge we_n_i) begin
      if (wr) begin
         wr = 1'b0;
         wd = dq_i;
         if (wd == 8'hf0) begin
            st = 2'h0;
            idm = 1'b0;
         end else if (st == 2'h3) begin
            st = 2'h0;
            if ($realtime >= busy_end) begin
               mem[wa] = (mem.exists(wa) ? mem[wa] : 8'hff) & wd;
               ld = wd;
               busy_end = $realtime + T_PROG;
            end
         end else if (st == 2'h0 && wa == 17'h05555 && wd == 8'haa) begin
            st = 2'h1;
         end else if (st == 2'h1 && wa == 17'h02aaa && wd == 8'h55) begin
            st = 2'h2;
         end else if (st == 2'h2 && esu && (wd == 8'h30 || (wd == 8'h10 && wa == 17'h05555))) begin
            if (wd == 8'h10) mem.delete();
            else for (int i = 0; i < 512; i++) mem.delete({wa[16:9], i[8:0]});
            ld = 8'hff;
            esu = 1'b0;
            st = 2'h0;
            busy_end = $realtime + T_ERASE;
         end else if (st == 2'h2 && wa == 17'h05555) begin
            st = (wd == 8'ha0) ? 2'h3 : 2'h0;
            esu = (wd == 8'h80);
            idm = idm || (wd == 8'h90);
         end else begin
            st = 2'h0;
         end
      end
   end
endmodule : pfc_flash_model
`default_nettype wire

/* dv/pfc_tb.sv */
// self-checking bench for the parallel flash host controller
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import pfc_pkg::*;
   localparam logic [7:0] MFR = 8'h3c; // arbitrary value
   localparam logic [7:0] DEV = 8'h5e; // arbitrary value
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic valid = 1'b0;
   logic en = 1'b1;
   logic [2:0] op = 3'h0;
   logic [16:0] a = 17'h00000;
   logic [7:0] d = 8'h00;
   logic ready, done, busy, ce_n, oe_n, we_n, dq_oe;
   logic [7:0] rdata, dq_h, dq_d, q;
   logic [16:0] fa;
   wire [7:0] bus;
   int n_fail = 0;
   int total_checks = 0;
   int cyc = 0;
   // data bus level from both drivers
   assign bus = dq_oe ? dq_h : dq_d;
   pfc_host u_pfc_host (.REF_CLK_I(clk), .RESET_I(rst), .CLK_EN_I(en),
      .CMD_VALID_I(valid), .CMD_READY_O(ready), .CMD_OP_I(op), .CMD_ADDR_I(a),
      .CMD_DATA_I(d), .DONE_O(done), .RDATA_O(rdata), .BUSY_O(busy),
      .FLASH_CE_N_O(ce_n), .FLASH_OE_N_O(oe_n), .FLASH_WE_N_O(we_n),
      .FLASH_ADDR_O(fa), .FLASH_DQ_O(dq_h), .FLASH_DQ_OE_O(dq_oe), .FLASH_DQ_I(bus));
   pfc_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_pfc_flash_model (.ce_n_i(ce_n),
      .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(fa), .dq_i(bus), .dq_o(dq_d));
   // clock
   initial begin
      forever #2.5 clk = ~clk;
   end
   // cycle ceiling cuts a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         end_of_test();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one command: wait idle, present it for one edge, wait for done
   task automatic run(input logic [2:0] o, input logic [16:0] ad, input logic [7:0] da);
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 100) begin
         @(posedge clk) #1;
         n++;
      end
      op = o;
      a = ad;
      d = da;
      valid = 1'b1;
      @(posedge clk) #1;
      valid = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 20000) begin
         @(posedge clk) #1;
         n++;
      end
      chk({7'h00, done}, 8'h01);
      q = rdata;
   endtask : run
   task automatic rd(input logic [16:0] ad, input logic [7:0] ex);
      run(PFC_OP_READ, ad, 8'h00);
      chk(q, ex);
   endtask : rd
   // read frozen mid-cycle by the clock enable; pins and state must hold
   task automatic t_freeze;
      int n;
      n = 0;
      op = PFC_OP_READ;
      a = 17'h00345;
      valid = 1'b1;
      @(posedge clk) #1;
      valid = 1'b0;
      repeat (3) @(posedge clk) #1;
      en = 1'b0;
      repeat (40) @(posedge clk) #1;
      chk({4'h0, ce_n, oe_n, we_n, busy}, 8'h03);
      en = 1'b1;
      while (done !== 1'b1 && n < 200) begin
         @(posedge clk) #1;
         n++;
      end
      chk({7'h00, done}, 8'h01);
      chk(rdata, 8'hff);
      $display("test freeze done");
   endtask : t_freeze
   task automatic t_idle;
      chk({1'b0, ce_n, oe_n, we_n, dq_oe, ready, busy, done}, 8'h74);
      rd(17'h00123, 8'hff);
      $display("test idle done");
   endtask : t_idle
   task automatic t_prog;
      run(PFC_OP_PROGRAM, 17'h00123, 8'h5a);
      chk(q, 8'h5a);
      rd(17'h00123, 8'h5a);
      run(PFC_OP_PROGRAM, 17'h00123, 8'h0f);
      rd(17'h00123, 8'h0a);
      run(PFC_OP_PROGRAM, 17'h1e005, 8'h00);
      rd(17'h1e005, 8'h00);
      run(PFC_OP_PROGRAM, 17'h00345, 8'h3c);
      $display("test program done");
   endtask : t_prog
   task automatic t_erase;
      run(PFC_OP_SECTOR_ERASE, 17'h001aa, 8'h00);
      chk(q, 8'hff);
      rd(17'h00123, 8'hff);
      rd(17'h00345, 8'h3c);
      run(PFC_OP_CHIP_ERASE, 17'h00000, 8'h00);
      rd(17'h00345, 8'hff);
      rd(17'h1e005, 8'hff);
      $display("test erase done");
   endtask : t_erase
   task automatic t_ident;
      run(PFC_OP_ID_ENTER, 17'h05555, 8'h00);
      rd(17'h00000, MFR);
      rd(17'h00001, DEV);
      run(PFC_OP_ID_EXIT, 17'h05555, 8'h00);
      rd(17'h00001, 8'hff);
      run(PFC_OP_ID_ENTER, 17'h05555, 8'h00);
      run(PFC_OP_READ_RESET, 17'h0abcd, 8'h00);
      rd(17'h00000, 8'hff);
      $display("test ident done");
   endtask : t_ident
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test
   // reset, then the scenarios in turn
   initial begin
      repeat (20) @(posedge clk);
      #1;
      rst = 1'b0;
      t_idle();
      t_prog();
      t_erase();
      t_ident();
      t_freeze();
      end_of_test();
   end
endmodule : tb
`default_nettype wire
